// ### include/rsx_defines.svh
`ifndef RSX_DEFINES_SVH
`define RSX_DEFINES_SVH
// opcode matching: top nibble and next two bits, plus the whole sleep word and the direction-load mask
`define RSX_OP_HI_ROT 4'h3
`define RSX_OP_HI_SUB 4'h0
`define RSX_OP_HI_XOR 4'h1
`define RSX_OP_HI_XORL 4'hF
`define RSX_OP_MID_ROTL 2'h1
`define RSX_OP_MID_ROTR 2'h0
`define RSX_OP_MID_SWP 2'h2
`define RSX_OP_MID_SUB 2'h2
`define RSX_OP_MID_XOR 2'h2
`define RSX_OP_SLEEP 12'h003
`define RSX_OP_DIR_MASK 12'hFF8
`define RSX_OP_DIR_BASE 12'h000
`define RSX_DIR_A 3'h5
`define RSX_DIR_B 3'h6
`define RSX_DIR_CFG2 3'h7
`define RSX_BYTE_ZERO 8'h00
`define RSX_WDOG_CLR 8'h00
// direction and config registers come up all ones so pins start as inputs
`define RSX_DIR_RST 8'hFF
`define RSX_PRE_CLR 8'h00
`define RSX_FADDR_ZERO 5'h00
`endif

// ### include/rsx_pkg.sv
package rsx_pkg;
   typedef struct packed {
      logic carry;
      logic digit_carry;
      logic zero;
   } rsx_flags_type;

   typedef struct packed {
      logic en;
      logic [4:0] addr;
      logic [7:0] data;
   } rsx_fwrite_type;

   typedef enum logic [0:0] {
      RSX_RUN = 1'b0,
      RSX_SLEEP = 1'b1
   } rsx_state_type;
endpackage : rsx_pkg

// ### design/rsx_exec.sv
`timescale 1ns/1ps
`include "rsx_defines.svh"

module rsx_exec
   import rsx_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [11:0] instr,
   input wire logic [7:0] file_rdata,
   input wire logic wake_event,
   output logic [4:0] file_raddr,
   output rsx_fwrite_type file_wr,
   output logic [7:0] work_reg,
   output rsx_flags_type status_flags,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic pin_change_wake_flag,
   output logic [7:0] watchdog_counter,
   output logic [7:0] watchdog_prescaler,
   output logic [7:0] dir_a_reg,
   output logic [7:0] dir_b_reg,
   output logic [7:0] secondary_config_register,
   output logic sleeping
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] w_ff;
   logic [7:0] nxt_w;
   rsx_flags_type flags_ff;
   rsx_flags_type nxt_flags;
   rsx_fwrite_type fwr_ff;
   rsx_fwrite_type nxt_fwr;
   logic tmo_ff;
   logic nxt_tmo;
   logic pdn_ff;
   logic nxt_pdn;
   logic pcw_ff;
   logic nxt_pcw;
   logic [7:0] wdog_ff;
   logic [7:0] nxt_wdog;
   logic [7:0] pre_ff;
   logic [7:0] nxt_pre;
   logic [7:0] dira_ff;
   logic [7:0] nxt_dira;
   logic [7:0] dirb_ff;
   logic [7:0] nxt_dirb;
   logic [7:0] cfg2_ff;
   logic [7:0] nxt_cfg2;
   rsx_state_type state_ff;
   rsx_state_type nxt_state;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic [3:0] op_hi;
   logic [1:0] op_mid;
   logic dest_file;
   logic [4:0] faddr;
   logic [7:0] fval;
   logic [7:0] lit;
   logic [8:0] diff;
   logic [4:0] ldiff;
   logic run;
   logic is_rotl;
   logic is_rotr;
   logic is_swap;
   logic is_sub;
   logic is_xorf;
   logic is_xorl;
   logic is_sleep;
   logic is_dir;

   assign op_hi = instr[11:8];
   assign op_mid = instr[7:6];
   assign dest_file = instr[5];
   assign faddr = instr[4:0];
   assign lit = instr[7:0];
   assign fval = file_rdata;
   // file register is read combinationally through this address
   assign file_raddr = faddr;
   // a 9-bit sum with W inverted plus one gives carry as not-borrow
   assign diff = {1'b0, fval} + {1'b0, ~w_ff} + 9'h001;
   assign ldiff = {1'b0, fval[3:0]} + {1'b0, ~w_ff[3:0]} + 5'h01;
   // halted core ignores the instruction stream entirely
   assign run = instr_valid && (state_ff == RSX_RUN);

   // ------------------------------------------------------------
   // opcode classes
   // ------------------------------------------------------------
   assign is_rotl = (op_hi == `RSX_OP_HI_ROT) && (op_mid == `RSX_OP_MID_ROTL);
   assign is_rotr = (op_hi == `RSX_OP_HI_ROT) && (op_mid == `RSX_OP_MID_ROTR);
   assign is_swap = (op_hi == `RSX_OP_HI_ROT) && (op_mid == `RSX_OP_MID_SWP);
   assign is_sub = (op_hi == `RSX_OP_HI_SUB) && (op_mid == `RSX_OP_MID_SUB);
   assign is_xorf = (op_hi == `RSX_OP_HI_XOR) && (op_mid == `RSX_OP_MID_XOR);
   assign is_xorl = (op_hi == `RSX_OP_HI_XORL);
   // the sleep word lies inside the direction-load range, so it is tested first
   assign is_sleep = (instr == `RSX_OP_SLEEP);
   assign is_dir = ((instr & `RSX_OP_DIR_MASK) == `RSX_OP_DIR_BASE);

   always_comb begin
      logic [7:0] res;
      logic wr_res, set_z;
      res = `RSX_BYTE_ZERO;
      wr_res = 1'b0;
      set_z = 1'b0;
      nxt_w = w_ff;
      nxt_flags = flags_ff;
      nxt_fwr = '0;
      nxt_tmo = tmo_ff;
      nxt_pdn = pdn_ff;
      nxt_pcw = pcw_ff;
      nxt_wdog = wdog_ff;
      nxt_pre = pre_ff;
      nxt_dira = dira_ff;
      nxt_dirb = dirb_ff;
      nxt_cfg2 = cfg2_ff;
      nxt_state = state_ff;
      case (state_ff)
         RSX_RUN: begin
            if (run) begin
               if (is_rotl) begin
                  res = {fval[6:0], flags_ff.carry};
                  nxt_flags.carry = fval[7];
                  wr_res = 1'b1;
               end else if (is_rotr) begin
                  res = {flags_ff.carry, fval[7:1]};
                  nxt_flags.carry = fval[0];
                  wr_res = 1'b1;
               end else if (is_swap) begin
                  res = {fval[3:0], fval[7:4]};
                  wr_res = 1'b1;
               end else if (is_sub) begin
                  res = diff[7:0];
                  nxt_flags.carry = diff[8];
                  nxt_flags.digit_carry = ldiff[4];
                  wr_res = 1'b1;
                  set_z = 1'b1;
               end else if (is_xorf) begin
                  res = w_ff ^ fval;
                  wr_res = 1'b1;
                  set_z = 1'b1;
               end else if (is_xorl) begin
                  res = w_ff ^ lit;
                  nxt_w = res;
                  set_z = 1'b1;
               end else if (is_sleep) begin
                  nxt_tmo = 1'b1;
                  nxt_pdn = 1'b0;
                  nxt_wdog = `RSX_WDOG_CLR;
                  nxt_pre = `RSX_PRE_CLR;
                  nxt_pcw = 1'b1;
                  nxt_state = RSX_SLEEP;
               end else if (is_dir) begin
                  // other operands (nop etc.) do nothing here
                  case (instr[2:0])
                     `RSX_DIR_A: nxt_dira = w_ff;
                     `RSX_DIR_B: nxt_dirb = w_ff;
                     `RSX_DIR_CFG2: nxt_cfg2 = w_ff;
                     default: nxt_cfg2 = cfg2_ff;
                  endcase
               end
               if (wr_res) begin
                  if (dest_file) begin
                     nxt_fwr.en = 1'b1;
                     nxt_fwr.addr = faddr;
                     nxt_fwr.data = res;
                  end else begin
                     nxt_w = res;
                  end
               end
               if (set_z) begin
                  nxt_flags.zero = (res == `RSX_BYTE_ZERO);
               end
            end
         end
         RSX_SLEEP: begin
            if (wake_event) begin
               nxt_state = RSX_RUN;
            end
         end
         default: nxt_state = RSX_RUN;
      endcase
   end

   // ------------------------------------------------------------
   // working register and status flags
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         w_ff <= `RSX_BYTE_ZERO;
         flags_ff <= '0;
      end else begin
         w_ff <= nxt_w;
         flags_ff <= nxt_flags;
      end
   end

   // ------------------------------------------------------------
   // file write strobe
   // ------------------------------------------------------------
   // registered so the file sees one clean write a cycle after the read
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fwr_ff <= '0;
      end else begin
         fwr_ff <= nxt_fwr;
      end
   end

   // ------------------------------------------------------------
   // power status flags
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tmo_ff <= 1'b1;
         pdn_ff <= 1'b1;
         pcw_ff <= 1'b0;
      end else begin
         tmo_ff <= nxt_tmo;
         pdn_ff <= nxt_pdn;
         pcw_ff <= nxt_pcw;
      end
   end

   // ------------------------------------------------------------
   // watchdog and prescaler
   // ------------------------------------------------------------
   // only the clear on sleep lives here; nothing in this project makes them count
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wdog_ff <= `RSX_WDOG_CLR;
         pre_ff <= `RSX_PRE_CLR;
      end else begin
         wdog_ff <= nxt_wdog;
         pre_ff <= nxt_pre;
      end
   end

   // ------------------------------------------------------------
   // direction and secondary config registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dira_ff <= `RSX_DIR_RST;
         dirb_ff <= `RSX_DIR_RST;
         cfg2_ff <= `RSX_DIR_RST;
      end else begin
         dira_ff <= nxt_dira;
         dirb_ff <= nxt_dirb;
         cfg2_ff <= nxt_cfg2;
      end
   end

   // ------------------------------------------------------------
   // run or sleep state
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= RSX_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign work_reg = w_ff;
   assign status_flags = flags_ff;
   assign file_wr = fwr_ff;
   assign timeout_flag = tmo_ff;
   assign powerdown_flag = pdn_ff;
   assign pin_change_wake_flag = pcw_ff;
   assign watchdog_counter = wdog_ff;
   assign watchdog_prescaler = pre_ff;
   assign dir_a_reg = dira_ff;
   assign dir_b_reg = dirb_ff;
   assign secondary_config_register = cfg2_ff;
   assign sleeping = (state_ff == RSX_SLEEP);

endmodule : rsx_exec

// ### bench/rsx_file_model.sv
`timescale 1ns/1ps
module rsx_file_model
   import rsx_pkg::*;
(
   input wire logic mclk,
   input wire logic [4:0] file_raddr,
   input wire rsx_fwrite_type file_wr,
   output logic [7:0] file_rdata
);
   logic [7:0] m [32];
   // read is combinational: the core samples data in the address cycle
   assign file_rdata = m[file_raddr];
   always @(posedge mclk) begin
      if (file_wr.en) m[file_wr.addr] <= file_wr.data;
   end
endmodule : rsx_file_model

// ### bench/rsx_exec_monitor.sv
`timescale 1ns/1ps
module rsx_exec_monitor
   import rsx_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [11:0] instr,
   input wire logic [7:0] file_rdata,
   input wire logic wake_event,
   input wire rsx_fwrite_type file_wr,
   input wire logic [7:0] work_reg,
   input wire rsx_flags_type status_flags,
   input wire logic timeout_flag,
   input wire logic powerdown_flag,
   input wire logic pin_change_wake_flag,
   input wire logic [7:0] watchdog_counter,
   input wire logic [7:0] watchdog_prescaler,
   input wire logic sleeping
);
   // ----------------------------------------
   // execution checks
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire go = instr_valid && !sleeping;
   wire [5:0] op = instr[11:6];
   wire c = status_flags.carry;
   xlit_a: assert property (go && instr[11:8] == 4'hF |=>
      work_reg == ($past(work_reg) ^ $past(instr[7:0])) && status_flags.zero == (work_reg == 8'h00))
      else $error("literal xor wrong");
   sleep_set_a: assert property (go && instr == 12'h003 |=> sleeping && timeout_flag &&
      !powerdown_flag && pin_change_wake_flag && watchdog_counter == 8'h00 &&
      watchdog_prescaler == 8'h00) else $error("sleep entry wrong");
   sleep_hold_a: assert property (sleeping && !wake_event |=>
      $stable(work_reg) && !file_wr.en) else $error("ran while asleep");
   rotl_a: assert property (go && op == 6'h0D && !instr[5] |=>
      work_reg == {$past(file_rdata[6:0]), $past(c)} && c == $past(file_rdata[7]))
      else $error("rotate left wrong");
   rotr_a: assert property (go && op == 6'h0C && instr[5] |=> file_wr.en &&
      file_wr.addr == $past(instr[4:0]) && file_wr.data == {$past(c), $past(file_rdata[7:1])}
      && c == $past(file_rdata[0])) else $error("rotate right wrong");
   sub_c_a: assert property (go && op == 6'h02 |=>
      c == ($past(file_rdata) >= $past(work_reg))) else $error("sub carry wrong");
   swap_a: assert property (go && op == 6'h0E && !instr[5] |=> $stable(status_flags) &&
      work_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}) else $error("swap wrong");
   xorf_a: assert property (go && op == 6'h06 && instr[5] |=>
      file_wr.data == ($past(work_reg) ^ $past(file_rdata))) else $error("file xor wrong");
   cover property (go && instr == 12'h003);
   cover property (sleeping && wake_event);
   cover property (go && op == 6'h02 ##1 !c);
endmodule : rsx_exec_monitor

bind rsx_exec rsx_exec_monitor mon (.*);

// ### bench/test_rotate_sub_xor_sleep_exec.sv
`timescale 1ns/1ps
module test_rotate_sub_xor_sleep_exec
   import rsx_pkg::*;
;
   logic mclk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, wake_event = 1'b0;
   logic [11:0] instr = 12'h000;
   logic [7:0] file_rdata, work_reg, watchdog_counter, watchdog_prescaler;
   logic [7:0] dir_a_reg, dir_b_reg, secondary_config_register;
   logic [4:0] file_raddr;
   logic timeout_flag, powerdown_flag, pin_change_wake_flag, sleeping;
   rsx_fwrite_type file_wr;
   rsx_flags_type status_flags;
   int bad_count = 0, comparisons = 0, cyc = 0;
   always #12.5 mclk = ~mclk;
   rsx_exec DUT (.*);
   rsx_file_model MEM (.*);
   // ----------------------------------------
   // access tasks and test sequence
   // ----------------------------------------
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one instruction; an idle cycle lets a file write land in the model before readback
   task ex(input logic [11:0] i);
      @(posedge mclk);
      instr <= i;
      instr_valid <= 1'b1;
      @(posedge mclk);
      instr_valid <= 1'b0;
      @(posedge mclk);
      #1;
   endtask : ex
   task stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   // generous ceiling: the sequence needs about 70 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 400) begin
         bad_count++;
         stop_test;
      end
   end
   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      chk("pd", 8'h01, 8'(powerdown_flag));
      chk("dira", 8'hFF, dir_a_reg);
      MEM.m[3] = 8'h03;
      MEM.m[4] = 8'h01;
      MEM.m[5] = 8'hE6;
      MEM.m[6] = 8'hA5;
      MEM.m[7] = 8'h5A;
      ex(12'hFB5); chk("w", 8'hB5, work_reg);
      ex(12'hFB5); chk("z", 8'h01, 8'(status_flags.zero));
      ex(12'hF02);
      ex(12'h0A3); chk("f3", 8'h01, MEM.m[3]);
      chk("c", 8'h01, 8'(status_flags.carry));
      chk("dc", 8'h01, 8'(status_flags.digit_carry));
      ex(12'h084); chk("w", 8'hFF, work_reg);
      chk("c", 8'h00, 8'(status_flags.carry));
      chk("dc", 8'h00, 8'(status_flags.digit_carry));
      ex(12'h345); chk("w", 8'hCC, work_reg);
      ex(12'h325); chk("f5", 8'hF3, MEM.m[5]);
      chk("c", 8'h00, 8'(status_flags.carry));
      ex(12'h386); chk("w", 8'h5A, work_reg);
      ex(12'h1A7); chk("f7", 8'h00, MEM.m[7]);
      chk("z", 8'h01, 8'(status_flags.zero));
      ex(12'h005); chk("dira", 8'h5A, dir_a_reg);
      ex(12'h006); chk("dirb", 8'h5A, dir_b_reg);
      ex(12'h007); chk("cfg2", 8'h5A, secondary_config_register);
      ex(12'h003); chk("pd", 8'h00, 8'(powerdown_flag));
      chk("wdt", 8'h00, watchdog_counter);
      chk("to", 8'h01, 8'(timeout_flag));
      chk("pcw", 8'h01, 8'(pin_change_wake_flag));
      chk("pre", 8'h00, watchdog_prescaler);
      ex(12'hFFF); chk("w", 8'h5A, work_reg);
      @(posedge mclk);
      wake_event <= 1'b1;
      @(posedge mclk);
      wake_event <= 1'b0;
      ex(12'hFFF); chk("w", 8'hA5, work_reg);
      stop_test;
   end
endmodule : test_rotate_sub_xor_sleep_exec
